// file: design/gcr_pkg.sv
`default_nettype none
package gcr_pkg;
  localparam int CLK_MHZ = 200;
  // bit frame times in microseconds
  localparam int SAMPLE_US = 100;
  localparam int BREAK_US  = 190;
  localparam int TSTRT_US  = 40;
  localparam int TDATA_US  = 120;
  localparam int TCYC_US   = 200;
  localparam int TTURN_US  = 100;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int BREAK_CYC  = BREAK_US * CLK_MHZ;
  localparam int TSTRT_CYC  = TSTRT_US * CLK_MHZ;
  localparam int TDATA_CYC  = TDATA_US * CLK_MHZ;
  localparam int TCYC_CYC   = TCYC_US * CLK_MHZ;
  localparam int TTURN_CYC  = TTURN_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam int WR_BIT = 7;
  localparam int CHG_BIT = 7;
  localparam int RST_BIT = 6;
  localparam logic [6:0] A_FLAGS1 = 7'h01;
  localparam logic [6:0] A_TMP    = 7'h02;
  localparam logic [6:0] A_CAPH   = 7'h03;
  localparam logic [6:0] A_PACKID = 7'h04;
  localparam logic [6:0] A_LEARN  = 7'h05;
  localparam logic [6:0] A_FLAGS2 = 7'h06;
  localparam logic [6:0] A_PPD    = 7'h07;
  localparam logic [6:0] A_PPU    = 7'h08;
  localparam logic [6:0] A_INACC  = 7'h09;
  localparam logic [6:0] A_VBAT   = 7'h0b;
  localparam logic [6:0] A_EMPTY  = 7'h0c;
  localparam logic [6:0] A_TCOMP  = 7'h0d;
  localparam logic [6:0] A_RCOMP  = 7'h0e;
  localparam logic [6:0] A_ENGH   = 7'h0f;
  localparam logic [6:0] A_ENGL   = 7'h10;
  localparam logic [6:0] A_RELC   = 7'h11;
  localparam logic [6:0] A_CURH   = 7'h12;
  localparam logic [6:0] A_CURL   = 7'h13;
  localparam logic [6:0] A_CAPL   = 7'h17;
  localparam logic [6:0] A_DCNT   = 7'h18;
  localparam logic [6:0] A_PPDAT  = 7'h1e;
  localparam logic [6:0] A_OFSEV  = 7'h38;
  localparam int RW_N = 11;
  localparam logic [3:0] NO_RW = 4'hf;
  localparam logic [7:0] RW_RST = 8'h00;
  localparam logic [7:0] FLG1_FIXED = 8'h04;
endpackage : gcr_pkg
`default_nettype wire

// file: design/gcr_rx.sv
`default_nettype none
module gcr_rx #(
  parameter int SAMPLE_CYC = gcr_pkg::SAMPLE_CYC,
  parameter int BREAK_CYC  = gcr_pkg::BREAK_CYC
) (
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic       i_line,
  input  wire logic       i_enable,
  output logic [7:0]      o_byte,
  output logic            o_byte_valid,
  output logic            o_break
);
  import gcr_pkg::*;
  typedef enum logic [1:0] {RX_IDLE, RX_LOW, RX_HOLD} gcr_rx_t;
  gcr_rx_t            st_r, st_nxt;
  logic [CNT_W-1:0]   cnt_r, cnt_nxt;
  logic [2:0]         bit_r, bit_nxt;
  logic [7:0]         sh_r, sh_nxt;
  logic               vld_nxt, brk_nxt;
  logic               full_r, full_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 1'b1;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    vld_nxt = 1'b0;
    brk_nxt = 1'b0;
    full_nxt = full_r;
    case (st_r)
      RX_IDLE: begin
        cnt_nxt = '0;
        if (!i_line) begin
          st_nxt = RX_LOW;
        end
      end
      RX_LOW: begin
        if (cnt_r == CNT_W'(SAMPLE_CYC - 1)) begin
          sh_nxt = {i_line, sh_r[7:1]};
          bit_nxt = bit_r + 1'b1;
          // byte only counts once the line is back high, so a break that
          // starts as an eighth bit never completes a command
          full_nxt = (bit_r == 3'd7);
          st_nxt = RX_HOLD;
        end
      end
      default: begin
        if (i_line) begin
          st_nxt = RX_IDLE;
          vld_nxt = full_r;
          full_nxt = 1'b0;
        end else if (cnt_r == CNT_W'(BREAK_CYC - 1)) begin
          bit_nxt = '0;
          full_nxt = 1'b0;
          brk_nxt = 1'b1;
        end
      end
    endcase
    if (!i_enable) begin
      st_nxt = RX_IDLE;
      bit_nxt = '0;
      vld_nxt = 1'b0;
      full_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st_r <= RX_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      full_r <= 1'b0;
      o_byte_valid <= 1'b0;
      o_break <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      full_r <= full_nxt;
      o_byte_valid <= vld_nxt;
      o_break <= brk_nxt;
    end
  end
  assign o_byte = sh_r;

  a_break_clears: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_break |-> bit_r == 3'd0 && !o_byte_valid)
    else $error("break left bits pending");
endmodule : gcr_rx
`default_nettype wire

// file: design/gcr_top.sv
`default_nettype none
module gcr_top #(
  parameter int SAMPLE_CYC = gcr_pkg::SAMPLE_CYC,
  parameter int BREAK_CYC  = gcr_pkg::BREAK_CYC,
  parameter int TSTRT_CYC  = gcr_pkg::TSTRT_CYC,
  parameter int TDATA_CYC  = gcr_pkg::TDATA_CYC,
  parameter int TCYC_CYC   = gcr_pkg::TCYC_CYC,
  parameter int TTURN_CYC  = gcr_pkg::TTURN_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_line_in,
  output logic             o_line_out,
  output logic             o_line_oe,
  input  wire logic        i_serial_reset_cmd,
  input  wire logic [15:0] i_sense_offset_voltage,
  input  wire logic [15:0] i_charge_threshold,
  input  wire logic        i_discharge_active,
  input  wire logic        i_capacity_update,
  input  wire logic [15:0] i_capacity_value,
  input  wire logic        i_capacity_inaccurate,
  input  wire logic        i_valid_discharge,
  input  wire logic        i_first_empty_warning,
  input  wire logic        i_final_empty_warning,
  input  wire logic [7:0]  i_temp_and_gauge,
  input  wire logic [7:0]  i_secondary_flags,
  input  wire logic [7:0]  i_prog_pin_pulldown,
  input  wire logic [7:0]  i_prog_pin_pullup,
  input  wire logic [7:0]  i_battery_voltage,
  input  wire logic [7:0]  i_energy_high,
  input  wire logic [7:0]  i_energy_low,
  input  wire logic [7:0]  i_relative_capacity,
  input  wire logic [7:0]  i_current_scale_high,
  input  wire logic [7:0]  i_current_scale_low,
  output logic             o_charging_flag,
  output logic             o_reset_indicator_flag,
  output logic [15:0]      o_available_capacity,
  output logic [7:0]       o_learned_full_capacity,
  output logic [7:0]       o_empty_threshold,
  output logic [7:0]       o_offset_event_control
);
  import gcr_pkg::*;

  typedef enum logic [1:0] {M_CMD, M_WDATA, M_READ} gcr_main_t;

  // index into the writable store, NO_RW for anything else
  function automatic logic [3:0] rw_index(input logic [6:0] a);
    logic [3:0] idx;
    idx = NO_RW;
    if (a == A_CAPH) begin
      idx = 4'h0;
    end else if (a == A_CAPL) begin
      idx = 4'h1;
    end else if (a == A_PACKID) begin
      idx = 4'h2;
    end else if (a == A_LEARN) begin
      idx = 4'h3;
    end else if (a == A_INACC) begin
      idx = 4'h4;
    end else if (a == A_EMPTY) begin
      idx = 4'h5;
    end else if (a == A_TCOMP) begin
      idx = 4'h6;
    end else if (a == A_RCOMP) begin
      idx = 4'h7;
    end else if (a == A_DCNT) begin
      idx = 4'h8;
    end else if (a == A_PPDAT) begin
      idx = 4'h9;
    end else if (a == A_OFSEV) begin
      idx = 4'ha;
    end
    return idx;
  endfunction : rw_index

  logic              sync1_r, sync2_r;
  logic [7:0]        rx_byte;
  logic              rx_valid, rx_break;
  logic              tx_low, tx_busy;
  gcr_main_t         st_r, st_nxt;
  logic [7:0]        cmd_r, cmd_nxt;
  logic [7:0]        rd_r, rd_nxt;
  logic              go_r, go_nxt;
  logic [7:0]        mem_r [RW_N];
  logic [7:0]        mem_nxt [RW_N];
  logic              chg_r, chg_nxt;
  logic              rst_ind_r, rst_ind_nxt;
  logic [7:0]        flags1;
  logic [7:0]        rd_mux;
  logic [6:0]        addr;
  logic [3:0]        widx;

  // pin sampled twice; the first stage feeds only the second
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= i_line_in;
      sync2_r <= sync1_r;
    end
  end

  gcr_rx #(
    .SAMPLE_CYC (SAMPLE_CYC),
    .BREAK_CYC  (BREAK_CYC)
  ) u_rx (
    .i_clock      (i_clock),
    .i_sys_rst    (i_sys_rst),
    .i_line       (sync2_r),
    .i_enable     (st_r != M_READ),
    .o_byte       (rx_byte),
    .o_byte_valid (rx_valid),
    .o_break      (rx_break)
  );

  gcr_tx #(
    .TSTRT_CYC (TSTRT_CYC),
    .TDATA_CYC (TDATA_CYC),
    .TCYC_CYC  (TCYC_CYC),
    .TTURN_CYC (TTURN_CYC)
  ) u_tx (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_start     (go_r),
    .i_data      (rd_r),
    .o_drive_low (tx_low),
    .o_busy      (tx_busy)
  );

  // open drain: only ever pulls low
  assign o_line_out = 1'b0;
  assign o_line_oe = tx_low;

  assign flags1 = {chg_r, rst_ind_r, FLG1_FIXED[5:4] | {1'b0, i_capacity_inaccurate},
                   i_valid_discharge, FLG1_FIXED[2], i_first_empty_warning,
                   i_final_empty_warning};
  assign addr = rx_byte[6:0];
  assign widx = rw_index(cmd_r[6:0]);

  always_comb begin
    rd_mux = 8'h00;
    if (addr == A_FLAGS1) begin
      rd_mux = flags1;
    end else if (addr == A_TMP) begin
      rd_mux = i_temp_and_gauge;
    end else if (addr == A_FLAGS2) begin
      rd_mux = i_secondary_flags;
    end else if (addr == A_PPD) begin
      rd_mux = i_prog_pin_pulldown;
    end else if (addr == A_PPU) begin
      rd_mux = i_prog_pin_pullup;
    end else if (addr == A_VBAT) begin
      rd_mux = i_battery_voltage;
    end else if (addr == A_ENGH) begin
      rd_mux = i_energy_high;
    end else if (addr == A_ENGL) begin
      rd_mux = i_energy_low;
    end else if (addr == A_RELC) begin
      rd_mux = i_relative_capacity;
    end else if (addr == A_CURH) begin
      rd_mux = i_current_scale_high;
    end else if (addr == A_CURL) begin
      rd_mux = i_current_scale_low;
    end else if (rw_index(addr) != NO_RW) begin
      rd_mux = mem_r[rw_index(addr)];
    end
  end

  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    rd_nxt = rd_r;
    go_nxt = 1'b0;
    mem_nxt = mem_r;
    // counting logic lands first so a host write in the same cycle wins
    if (i_capacity_update) begin
      mem_nxt[0] = i_capacity_value[15:8];
      mem_nxt[1] = i_capacity_value[7:0];
    end
    case (st_r)
      M_CMD: begin
        if (rx_valid) begin
          cmd_nxt = rx_byte;
          if (rx_byte[WR_BIT]) begin
            st_nxt = M_WDATA;
          end else begin
            rd_nxt = rd_mux;
            go_nxt = 1'b1;
            st_nxt = M_READ;
          end
        end
      end
      M_WDATA: begin
        if (rx_valid) begin
          st_nxt = M_CMD;
          if (widx != NO_RW) begin
            mem_nxt[widx] = rx_byte;
          end
        end
      end
      default: begin
        if (!tx_busy && !go_r) begin
          st_nxt = M_CMD;
        end
      end
    endcase
    if (rx_break) begin
      st_nxt = M_CMD;
    end
  end

  always_comb begin
    // a fresh discharge or a threshold miss drops it immediately
    chg_nxt = (i_sense_offset_voltage > i_charge_threshold)
              && !i_discharge_active;
    rst_ind_nxt = rst_ind_r;
    if (chg_r && (i_first_empty_warning || (i_capacity_update &&
        i_capacity_value[15:8] == mem_r[3]))) begin
      rst_ind_nxt = 1'b0;
    end
    if (i_serial_reset_cmd) begin
      rst_ind_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st_r <= M_CMD;
      cmd_r <= '0;
      rd_r <= '0;
      go_r <= 1'b0;
      chg_r <= 1'b0;
      rst_ind_r <= 1'b1;
      for (int i = 0; i < RW_N; i++) begin
        mem_r[i] <= RW_RST;
      end
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      rd_r <= rd_nxt;
      go_r <= go_nxt;
      chg_r <= chg_nxt;
      rst_ind_r <= rst_ind_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign o_charging_flag = chg_r;
  assign o_reset_indicator_flag = rst_ind_r;
  assign o_available_capacity = {mem_r[0], mem_r[1]};
  assign o_learned_full_capacity = mem_r[3];
  assign o_empty_threshold = mem_r[5];
  assign o_offset_event_control = mem_r[10];

  sequence s_read_cmd;
    st_r == M_CMD && rx_valid && !rx_byte[WR_BIT] && !rx_break;
  endsequence
  sequence s_write_pair;
    st_r == M_WDATA && rx_valid && !rx_break && !i_capacity_update;
  endsequence

  a_cmd_eight_bits: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    cmd_r != $past(cmd_r) |-> $past(rx_valid))
    else $error("command taken without full byte");
  a_read_starts: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_read_cmd |=> go_r && st_r == M_READ ##1 tx_busy)
    else $error("read did not start reply");
  a_write_stores: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_write_pair and (cmd_r[6:0] == A_CAPL)
    |=> mem_r[1] == $past(rx_byte))
    else $error("write data not stored");
  a_addr_decode: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_read_cmd and (rx_byte[6:0] == A_EMPTY) |=> rd_r == mem_r[5])
    else $error("read address decoded wrong");
  a_flags_layout: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_read_cmd and (rx_byte[6:0] == A_FLAGS1)
    |=> rd_r[CHG_BIT] == $past(chg_r) && rd_r[RST_BIT] == $past(rst_ind_r))
    else $error("primary flag layout wrong");
  a_chg_follow: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_sense_offset_voltage > i_charge_threshold) && !i_discharge_active
    |=> chg_r)
    else $error("charging flag not set");
  a_chg_drop: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_discharge_active || i_sense_offset_voltage <= i_charge_threshold
    |=> !chg_r)
    else $error("charging flag not cleared");
  a_reset_sets: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_serial_reset_cmd |=> rst_ind_r)
    else $error("reset indicator not set");
  a_reset_clears: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    chg_r && i_first_empty_warning && !i_serial_reset_cmd |=> !rst_ind_r)
    else $error("reset indicator not cleared");
  a_cap_split: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_capacity_update && st_r == M_CMD |=> o_available_capacity == $past(i_capacity_value))
    else $error("capacity bytes split wrong");
  a_unmapped_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_read_cmd and (rx_byte[6:0] == 7'h7f) |=> rd_r == 8'h00)
    else $error("unmapped address read nonzero");
  a_break_abort: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    rx_break |=> st_r == M_CMD)
    else $error("break did not abort command");
  a_line_pull_only: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_line_oe |-> !o_line_out && st_r == M_READ)
    else $error("line pulled outside a reply");
endmodule : gcr_top
`default_nettype wire

// file: design/gcr_tx.sv
`default_nettype none
module gcr_tx #(
  parameter int TSTRT_CYC = gcr_pkg::TSTRT_CYC,
  parameter int TDATA_CYC = gcr_pkg::TDATA_CYC,
  parameter int TCYC_CYC  = gcr_pkg::TCYC_CYC,
  parameter int TTURN_CYC = gcr_pkg::TTURN_CYC
) (
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic       i_start,
  input  wire logic [7:0] i_data,
  output logic            o_drive_low,
  output logic            o_busy
);
  import gcr_pkg::*;
  typedef enum logic [1:0] {TX_IDLE, TX_TURN, TX_BIT} gcr_tx_t;
  gcr_tx_t            st_r, st_nxt;
  logic [CNT_W-1:0]   cnt_r, cnt_nxt;
  logic [2:0]         bit_r, bit_nxt;
  logic [7:0]         sh_r, sh_nxt;
  logic               low_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 1'b1;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    low_nxt = 1'b0;
    case (st_r)
      TX_IDLE: begin
        cnt_nxt = '0;
        if (i_start) begin
          sh_nxt = i_data;
          bit_nxt = '0;
          st_nxt = TX_TURN;
        end
      end
      TX_TURN: begin
        if (cnt_r == CNT_W'(TTURN_CYC - 1)) begin
          cnt_nxt = '0;
          st_nxt = TX_BIT;
        end
      end
      default: begin
        // lsb first, zero held low longer than a one
        low_nxt = (cnt_nxt < CNT_W'(TSTRT_CYC)) ||
                  (!sh_r[0] && cnt_nxt < CNT_W'(TDATA_CYC));
        if (cnt_r == CNT_W'(TCYC_CYC - 1)) begin
          cnt_nxt = '0;
          low_nxt = 1'b1;
          sh_nxt = {1'b0, sh_r[7:1]};
          bit_nxt = bit_r + 1'b1;
          if (bit_r == 3'd7) begin
            st_nxt = TX_IDLE;
            low_nxt = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st_r <= TX_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      o_drive_low <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      o_drive_low <= low_nxt;
    end
  end
  assign o_busy = (st_r != TX_IDLE);
endmodule : gcr_tx
`default_nettype wire

// file: sim/gcr_host.sv
`default_nettype none
module gcr_host (
  input  wire logic i_clock,
  input  wire logic i_line,
  output var  logic o_line_low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_line_low = 1'b0;

  // lsb first, 37-cycle frames, sample point after the end of a one's low pulse and before the end of a zero's
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge i_clock) o_line_low = 1'b1;
      repeat (b[i] ? 6 : 26) @(negedge i_clock);
      o_line_low = 1'b0;
      // short tail on a zero so a reply is never missed
      repeat (b[i] ? 30 : 10) @(negedge i_clock);
    end
  endtask : send_bits

  // held low past the break time, then idle high before a new command
  task automatic send_break();
    @(negedge i_clock) o_line_low = 1'b1;
    repeat (60) @(negedge i_clock);
    o_line_low = 1'b0;
    repeat (20) @(negedge i_clock);
  endtask : send_break

  // low pulse width decides the bit, short low is a one
  task automatic recv_byte(output logic [7:0] b);
    int n;
    b = 'x;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (i_line && n < 200) begin
        @(negedge i_clock);
        n++;
      end
      if (n >= 200) return;
      n = 0;
      while (!i_line && n < 100) begin
        @(negedge i_clock);
        n++;
      end
      b[i] = (n < 16);
    end
  endtask : recv_byte
endmodule : gcr_host
`default_nettype wire

// file: sim/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gcr_pkg::*;

  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

  logic        i_clock, i_sys_rst, host_low, oe, rcmd, dis, cupd, ci, vdq, e1, ef, chg, rif;
  logic        lo;
  logic [15:0] sense, thr, cval, cap;
  logic [7:0]  lrn, emp, ofs, d, v, vals [11];
  logic [7:0]  ro   [10];
  logic [6:0]  rw_a [11] = '{7'h03, 7'h04, 7'h05, 7'h09, 7'h0c, 7'h0d, 7'h0e, 7'h17,
                             7'h18, 7'h1e, 7'h38};
  logic [6:0]  ro_a [10] = '{7'h02, 7'h06, 7'h07, 7'h08, 7'h0b, 7'h0f, 7'h10, 7'h11,
                             7'h12, 7'h13};
  int          fail_count = 0;
  int          compares = 0;
  int          n;
  // shortened link timing so a run stays small
  localparam int T_SHORT = 20;
  localparam int T_LONG  = 40;
  localparam int T_START = 8;
  localparam int T_ZERO  = 24;
  // open drain with pull-up: the device pin level shows only while enabled
  wire logic   line = ~host_low & (oe ? lo : 1'b1);

  gcr_host host (.i_clock(i_clock), .i_line(line), .o_line_low(host_low));

  gcr_top #(.SAMPLE_CYC(T_SHORT), .BREAK_CYC(T_LONG), .TSTRT_CYC(T_START),
    .TDATA_CYC(T_ZERO), .TCYC_CYC(T_LONG), .TTURN_CYC(T_SHORT)) dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_line_in(line), .o_line_out(lo),
    .o_line_oe(oe), .i_serial_reset_cmd(rcmd), .i_sense_offset_voltage(sense),
    .i_charge_threshold(thr), .i_discharge_active(dis), .i_capacity_update(cupd),
    .i_capacity_value(cval), .i_capacity_inaccurate(ci), .i_valid_discharge(vdq),
    .i_first_empty_warning(e1), .i_final_empty_warning(ef), .i_temp_and_gauge(ro[0]),
    .i_secondary_flags(ro[1]), .i_prog_pin_pulldown(ro[2]), .i_prog_pin_pullup(ro[3]),
    .i_battery_voltage(ro[4]), .i_energy_high(ro[5]), .i_energy_low(ro[6]),
    .i_relative_capacity(ro[7]), .i_current_scale_high(ro[8]),
    .i_current_scale_low(ro[9]), .o_charging_flag(chg), .o_reset_indicator_flag(rif),
    .o_available_capacity(cap), .o_learned_full_capacity(lrn), .o_empty_threshold(emp),
    .o_offset_event_control(ofs));

  task automatic wr(input logic [6:0] a, input logic [7:0] val);
    host.send_bits({1'b1, a}, 8);
    host.send_bits(val, 8);
    repeat (10) @(negedge i_clock);
  endtask : wr

  // receiver is off while replying, so let the reply frame finish
  task automatic rd(input logic [6:0] a, output logic [7:0] val);
    host.send_bits({1'b0, a}, 8);
    host.recv_byte(val);
    repeat (45) @(negedge i_clock);
  endtask : rd

  function automatic logic [7:0] exp_flags(input logic c, input logic r);
    return {c, r, 1'b0, ci, vdq, 1'b1, e1, ef};
  endfunction : exp_flags

  task automatic results();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  initial begin
    repeat (60000) @(posedge i_clock);
    fail_count++;
    results();
  end

  initial begin
    i_sys_rst = 1'b1;
    {rcmd, dis, cupd, ci, vdq, e1, ef} = 7'h00;
    cval = 16'h0000;
    sense = 16'h0000;
    thr = 16'h0100;
    foreach (ro[i]) ro[i] = 8'h00;
    void'($urandom(32'he2a7));
    repeat (12) @(negedge i_clock);
    i_sys_rst = 1'b0;
    `CHK(rif, 1'b1)
    `CHK(cap, 16'h0000)
    {ci, vdq, ef} = 3'($urandom);
    rd(A_FLAGS1, d);
    `CHK(d, exp_flags(1'b0, 1'b1))
    foreach (rw_a[i]) begin
      vals[i] = 8'($urandom);
      wr(rw_a[i], vals[i]);
      rd(rw_a[i], d);
      `CHK(d, vals[i])
    end
    `CHK(cap, {vals[0], vals[7]})
    `CHK(emp, vals[4])
    `CHK(ofs, vals[10])
    // learned capacity kept apart from the high byte so no full-charge match yet
    wr(A_LEARN, vals[0] ^ 8'h01);
    `CHK(lrn, vals[0] ^ 8'h01)
    foreach (ro_a[i]) begin
      ro[i] = 8'($urandom);
      rd(ro_a[i], d);
      `CHK(d, ro[i])
    end
    wr(7'h7f, 8'hff);
    rd(7'h7f, d);
    `CHK(d, 8'h00)
    wr(A_TMP, ~ro[0]);
    rd(A_TMP, d);
    `CHK(d, ro[0])
    // seven bits only: nothing may answer, then a break clears the partial byte
    host.send_bits({1'b0, A_CAPL}, 7);
    n = 0;
    repeat (120) begin
      @(negedge i_clock);
      n += int'(oe);
    end
    `CHK(n, 0)
    host.send_break();
    rd(A_CAPL, d);
    `CHK(d, vals[7])
    thr = {1'b0, 15'($urandom)};
    sense = thr + 16'h0001;
    repeat (4) @(negedge i_clock);
    `CHK(chg, 1'b1)
    rd(A_FLAGS1, d);
    `CHK(d, exp_flags(1'b1, 1'b1))
    dis = 1'b1;
    repeat (4) @(negedge i_clock);
    `CHK(chg, 1'b0)
    dis = 1'b0;
    sense = thr;
    repeat (4) @(negedge i_clock);
    `CHK(chg, 1'b0)
    sense = thr + 16'h0001;
    e1 = 1'b1;
    repeat (4) @(negedge i_clock);
    `CHK(rif, 1'b0)
    e1 = 1'b0;
    rcmd = 1'b1;
    @(negedge i_clock);
    rcmd = 1'b0;
    repeat (4) @(negedge i_clock);
    `CHK(rif, 1'b1)
    cval = {vals[0] ^ 8'h01, 8'($urandom)};
    cupd = 1'b1;
    @(negedge i_clock);
    cupd = 1'b0;
    repeat (4) @(negedge i_clock);
    `CHK(cap, cval)
    `CHK(rif, 1'b0)
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_sys_rst = 1'b0;
    `CHK(rif, 1'b1)
    `CHK(lrn, 8'h00)
    results();
  end
endmodule : tb
`default_nettype wire
